// ---- design/cpu_incdec_div_branch_exec.sv ----
`timescale 1ns/10ps
// Functional notes
// - minus one wraps 00 to ff, flags kept
// - minus one: acc, bank, direct, indirect forms
// - read-modify-write of ports uses output latch
// - divide a by b, quotient a, remainder b
// - divisor zero sets range flag, clears carry
// - count down, no flags, branch if nonzero
// - count down: bank two bytes, direct three
// - plus one wraps ff to 00, flags kept
// - plus one: acc, bank, direct, indirect forms
// - data pointer sixteen bit increment, no flags
// - branch on bit one, bit untouched
// - branch on bit one and clear it
// - bit clear test of port uses latch
// - branch on carry set, no flag change
// - target is next instruction plus displacement
module cpu_incdec_div_branch_exec (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // program memory, data valid before the next rising edge, in the same cycle as the address
  output logic      [15:0]      prog_addr_q,
  input  wire logic [7:0]       prog_data,
  // port pins and output latches
  input  wire logic [3:0][7:0]  port_pins,
  output logic      [3:0][7:0]  port_lat_q,
  // core state seen from outside
  output logic      [7:0]       acc_q,
  output logic      [7:0]       b_q,
  output logic      [7:0]       psw_q,
  output logic      [7:0]       pointer_high_byte_q,
  output logic      [7:0]       pointer_low_byte_q,
  output logic                  instr_done_q,
  output logic                  illegal_op_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // decoding, shared by the fetch and execute steps

  function automatic cpu_exec_pkg::op_class_e op_class(input logic [7:0] op);
    if (op == cpu_exec_pkg::OP_INC_A || op == cpu_exec_pkg::OP_INC_DIR ||
        op[7:1] == cpu_exec_pkg::OPH_INC_IND || op[7:3] == cpu_exec_pkg::OPH_INC_RN) begin
      return cpu_exec_pkg::CL_INC;
    end
    if (op == cpu_exec_pkg::OP_DEC_A || op == cpu_exec_pkg::OP_DEC_DIR ||
        op[7:1] == cpu_exec_pkg::OPH_DEC_IND || op[7:3] == cpu_exec_pkg::OPH_DEC_RN) begin
      return cpu_exec_pkg::CL_DEC;
    end
    if (op == cpu_exec_pkg::OP_COUNT_DOWN_BRANCH_OP_DIR || op[7:3] == cpu_exec_pkg::OPH_COUNT_DOWN_BRANCH_OP_RN) begin
      return cpu_exec_pkg::CL_COUNT_DOWN_BRANCH_OP;
    end
    if (op == cpu_exec_pkg::OP_INC_DATA_POINTER) return cpu_exec_pkg::CL_DATA_POINTER;
    if (op == cpu_exec_pkg::OP_DIV)      return cpu_exec_pkg::CL_DIV;
    if (op == cpu_exec_pkg::OP_JB)       return cpu_exec_pkg::CL_JB;
    if (op == cpu_exec_pkg::OP_JBC)      return cpu_exec_pkg::CL_JBC;
    if (op == cpu_exec_pkg::OP_JC)       return cpu_exec_pkg::CL_JC;
    return cpu_exec_pkg::CL_NONE;
  endfunction : op_class

  function automatic cpu_exec_pkg::op_mode_e op_mode(input logic [7:0] op);
    cpu_exec_pkg::op_class_e cl;
    cl = op_class(op);
    if (cl == cpu_exec_pkg::CL_JB || cl == cpu_exec_pkg::CL_JBC) return cpu_exec_pkg::MD_BIT;
    if (cl != cpu_exec_pkg::CL_INC && cl != cpu_exec_pkg::CL_DEC &&
        cl != cpu_exec_pkg::CL_COUNT_DOWN_BRANCH_OP) return cpu_exec_pkg::MD_NONE;
    if (op[3]) return cpu_exec_pkg::MD_RN;
    if (op[2:0] == 3'h4) return cpu_exec_pkg::MD_ACC;
    if (op[2:0] == 3'h5) return cpu_exec_pkg::MD_DIR;
    return cpu_exec_pkg::MD_IND;
  endfunction : op_mode

  function automatic logic [1:0] op_len(input logic [7:0] op);
    cpu_exec_pkg::op_class_e cl;
    cl = op_class(op);
    if (cl == cpu_exec_pkg::CL_JB || cl == cpu_exec_pkg::CL_JBC ||
        op == cpu_exec_pkg::OP_COUNT_DOWN_BRANCH_OP_DIR) return cpu_exec_pkg::LEN_THREE;
    if (cl == cpu_exec_pkg::CL_COUNT_DOWN_BRANCH_OP || cl == cpu_exec_pkg::CL_JC ||
        op_mode(op) == cpu_exec_pkg::MD_DIR) return cpu_exec_pkg::LEN_TWO;
    return cpu_exec_pkg::LEN_ONE;
  endfunction : op_len

  function automatic logic [2:0] op_cycles(input logic [7:0] op);
    unique case (op_class(op))
      cpu_exec_pkg::CL_DIV:  return cpu_exec_pkg::CYC_DIV;
      cpu_exec_pkg::CL_COUNT_DOWN_BRANCH_OP, cpu_exec_pkg::CL_JB, cpu_exec_pkg::CL_JBC,
      cpu_exec_pkg::CL_JC, cpu_exec_pkg::CL_DATA_POINTER: return cpu_exec_pkg::CYC_TWO;
      default: return cpu_exec_pkg::CYC_ONE;
    endcase
  endfunction : op_cycles

  ////////////////////////////////////////////////////////////////////////////////
  // machine cycle enable, one pulse every MC_CLKS sys_clk cycles

  logic [3:0] div_cnt_q, div_cnt_d;
  logic       mc_tick_q, mc_tick_d;

  always_comb begin
    mc_tick_d = (div_cnt_q == cpu_exec_pkg::MC_CLKS - 4'h1);
    div_cnt_d = mc_tick_d ? 4'h0 : div_cnt_q + 4'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_cnt_q <= 4'h0;
      mc_tick_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      mc_tick_q <= mc_tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops per port

  logic [3:0][7:0] pin_meta_q, pin_sync_q;

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_pin_sync
      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          pin_meta_q[gp] <= 8'h00;
          pin_sync_q[gp] <= 8'h00;
        end else begin
          pin_meta_q[gp] <= port_pins[gp];
          pin_sync_q[gp] <= pin_meta_q[gp];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // data memory

  logic [7:0] ram_raddr, ram_rdata_q, ram_waddr, ram_wdata;
  logic       ram_we;

  data_ram u_ram (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .raddr   (ram_raddr),
    .rdata_q (ram_rdata_q),
    .we      (ram_we),
    .waddr   (ram_waddr),
    .wdata   (ram_wdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer and execution

  cpu_exec_pkg::exec_state_e state_q, state_d;
  logic [15:0]     pc_q, pc_d, prog_addr_d, target;
  logic [7:0]      op_q, op_d, arg1_q, arg1_d, arg2_q, arg2_d, ea_q, ea_d, opnd_q, opnd_d;
  logic            ea_sfr_q, ea_sfr_d;
  logic [7:0]      acc_d, b_d, psw_d, dph_d, dpl_d;
  logic [3:0][7:0] port_lat_d;
  logic [2:0]      mc_cnt_q, mc_cnt_d;
  logic            done_d, illegal_d;
  cpu_exec_pkg::op_class_e cls;
  cpu_exec_pkg::op_mode_e  md;
  logic [7:0]      sfr_val, cur, res, rel, bit_addr_byte, bank_base;
  logic            is_port, wr, take, bit_val;

  always_comb begin
    state_d = state_q;  pc_d = pc_q;  prog_addr_d = prog_addr_q;
    op_d = op_q;  arg1_d = arg1_q;  arg2_d = arg2_q;  ea_d = ea_q;  ea_sfr_d = ea_sfr_q;
    opnd_d = opnd_q;  acc_d = acc_q;  b_d = b_q;  psw_d = psw_q;
    dph_d = pointer_high_byte_q;  dpl_d = pointer_low_byte_q;  port_lat_d = port_lat_q;
    done_d = 1'b0;  illegal_d = 1'b0;
    ram_raddr = ea_q;  ram_we = 1'b0;  ram_waddr = ea_q;  ram_wdata = 8'h00;
    cls = op_class(op_q);
    md  = op_mode(op_q);
    bank_base = {3'h0, psw_q[cpu_exec_pkg::PSW_RS1:cpu_exec_pkg::PSW_RS0], 3'h0};
    bit_addr_byte = arg1_q[7] ? {arg1_q[7:3], 3'h0}
                              : cpu_exec_pkg::BIT_RAM_BASE + {4'h0, arg1_q[6:3]};
    mc_cnt_d = (state_q == cpu_exec_pkg::ST_OPC) ? 3'h0 : mc_cnt_q + {2'h0, mc_tick_q};
    // sfr read; only a plain bit test sees the pins, modifying forms see the latch
    is_port = (ea_q[7:6] == 2'h2) && (ea_q[3:0] == 4'h0);
    sfr_val = 8'h00;
    if (is_port) begin
      sfr_val = (cls == cpu_exec_pkg::CL_JB) ? pin_sync_q[ea_q[5:4]]
                                             : port_lat_q[ea_q[5:4]];
    end else begin
      case (ea_q)
        cpu_exec_pkg::SFR_ACC: sfr_val = acc_q;
        cpu_exec_pkg::SFR_B:   sfr_val = b_q;
        cpu_exec_pkg::SFR_PSW: sfr_val = psw_q;
        cpu_exec_pkg::SFR_DPL: sfr_val = pointer_low_byte_q;
        cpu_exec_pkg::SFR_DPH: sfr_val = pointer_high_byte_q;
        default:               sfr_val = 8'h00;  // unimplemented sfrs read zero
      endcase
    end
    cur     = (md == cpu_exec_pkg::MD_ACC) ? acc_q : (ea_sfr_q ? sfr_val : opnd_q);
    bit_val = cur[arg1_q[2:0]];
    rel     = (op_len(op_q) == cpu_exec_pkg::LEN_THREE) ? arg2_q : arg1_q;
    target  = pc_q + {{8{rel[7]}}, rel};
    res = 8'h00;
    wr = 1'b0;
    take = 1'b0;
    unique case (state_q)
      cpu_exec_pkg::ST_FETCH: begin
        prog_addr_d = pc_q;
        state_d = cpu_exec_pkg::ST_OPC;
      end
      cpu_exec_pkg::ST_OPC: begin
        op_d = prog_data;
        pc_d = pc_q + 16'h0001;
        prog_addr_d = pc_q + 16'h0001;
        state_d = (op_len(prog_data) == cpu_exec_pkg::LEN_ONE) ? cpu_exec_pkg::ST_PREP
                                                                : cpu_exec_pkg::ST_ARG1;
      end
      cpu_exec_pkg::ST_ARG1: begin
        arg1_d = prog_data;
        pc_d = pc_q + 16'h0001;
        prog_addr_d = pc_q + 16'h0001;
        state_d = (op_len(op_q) == cpu_exec_pkg::LEN_THREE) ? cpu_exec_pkg::ST_ARG2
                                                             : cpu_exec_pkg::ST_PREP;
      end
      cpu_exec_pkg::ST_ARG2: begin
        arg2_d = prog_data;
        pc_d = pc_q + 16'h0001;
        prog_addr_d = pc_q + 16'h0001;
        state_d = cpu_exec_pkg::ST_PREP;
      end
      cpu_exec_pkg::ST_PREP: begin
        // operand addressing; sfr-space addresses are read from sfr_val later
        ea_sfr_d = 1'b0;
        state_d = cpu_exec_pkg::ST_READ;
        unique case (md)
          cpu_exec_pkg::MD_RN:  ea_d = bank_base | {5'h00, op_q[2:0]};
          cpu_exec_pkg::MD_IND: begin
            ram_raddr = bank_base | {7'h00, op_q[0]};
            state_d = cpu_exec_pkg::ST_IND;
          end
          cpu_exec_pkg::MD_DIR: begin
            ea_d = arg1_q;
            ea_sfr_d = arg1_q[7];
          end
          cpu_exec_pkg::MD_BIT: begin
            ea_d = bit_addr_byte;
            ea_sfr_d = arg1_q[7];
          end
          cpu_exec_pkg::MD_ACC, cpu_exec_pkg::MD_NONE: state_d = cpu_exec_pkg::ST_EXEC;
        endcase
        ram_raddr = (md == cpu_exec_pkg::MD_IND) ? ram_raddr : ea_d;
      end
      cpu_exec_pkg::ST_IND: begin
        ea_d = ram_rdata_q;  // indirect reaches the whole ram, never sfrs
        ram_raddr = ram_rdata_q;
        state_d = cpu_exec_pkg::ST_READ;
      end
      cpu_exec_pkg::ST_READ: begin
        opnd_d = ram_rdata_q;
        state_d = cpu_exec_pkg::ST_EXEC;
      end
      cpu_exec_pkg::ST_EXEC: begin
        state_d = cpu_exec_pkg::ST_WAIT;
        unique case (cls)
          cpu_exec_pkg::CL_INC: begin
            res = cur + 8'h01;
            wr = 1'b1;
          end
          cpu_exec_pkg::CL_DEC: begin
            res = cur - 8'h01;
            wr = 1'b1;
          end
          cpu_exec_pkg::CL_COUNT_DOWN_BRANCH_OP: begin
            res = cur - 8'h01;
            wr = 1'b1;
            take = (res != 8'h00);
          end
          cpu_exec_pkg::CL_DATA_POINTER: begin
            {dph_d, dpl_d} = {pointer_high_byte_q, pointer_low_byte_q} + 16'h0001;
          end
          cpu_exec_pkg::CL_DIV: begin
            psw_d[cpu_exec_pkg::PSW_CY] = 1'b0;
            if (b_q == 8'h00) begin
              psw_d[cpu_exec_pkg::PSW_OV] = 1'b1;
            end else begin
              acc_d = acc_q / b_q;
              b_d   = acc_q % b_q;
              psw_d[cpu_exec_pkg::PSW_OV] = 1'b0;
            end
          end
          cpu_exec_pkg::CL_JB: take = bit_val;
          cpu_exec_pkg::CL_JBC: begin
            take = bit_val;
            res = cur & ~(8'h01 << arg1_q[2:0]);
            wr = bit_val;
          end
          cpu_exec_pkg::CL_JC: take = psw_q[cpu_exec_pkg::PSW_CY];
          cpu_exec_pkg::CL_NONE: illegal_d = 1'b1;  // unsupported opcode runs as a nop
        endcase
        if (take) begin
          pc_d = target;
        end
        // write back; sfr targets land in the real register, ports in the latch
        if (wr) begin
          if (md == cpu_exec_pkg::MD_ACC) begin
            acc_d = res;
          end else if (!ea_sfr_q) begin
            ram_we = 1'b1;
            ram_wdata = res;
          end else if (is_port) begin
            port_lat_d[ea_q[5:4]] = res;
          end else begin
            case (ea_q)
              cpu_exec_pkg::SFR_ACC: acc_d = res;
              cpu_exec_pkg::SFR_B:   b_d = res;
              cpu_exec_pkg::SFR_PSW: psw_d = res;
              cpu_exec_pkg::SFR_DPL: dpl_d = res;
              cpu_exec_pkg::SFR_DPH: dph_d = res;
              default: ;  // writes to absent sfrs are dropped
            endcase
          end
        end
      end
      cpu_exec_pkg::ST_WAIT: begin
        // hold for the full machine-cycle count; a tick that fell before this state is
        // already counted, so the test is at-or-past rather than equal
        if (mc_tick_q && (mc_cnt_q >= op_cycles(op_q) - 3'h1)) begin
          done_d = 1'b1;
          state_d = cpu_exec_pkg::ST_FETCH;
        end
      end
      default: state_d = cpu_exec_pkg::ST_FETCH;  // codes 9..15 are illegal
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= cpu_exec_pkg::ST_FETCH;
      pc_q <= cpu_exec_pkg::PC_RST;
      prog_addr_q <= cpu_exec_pkg::PC_RST;
      op_q <= 8'h00;  arg1_q <= 8'h00;  arg2_q <= 8'h00;
      ea_q <= 8'h00;  ea_sfr_q <= 1'b0;  opnd_q <= 8'h00;
      acc_q <= 8'h00;  b_q <= 8'h00;  psw_q <= cpu_exec_pkg::PSW_RST;
      pointer_high_byte_q <= 8'h00;
      pointer_low_byte_q <= 8'h00;
      port_lat_q <= {4{cpu_exec_pkg::PORT_RST}};
      mc_cnt_q <= 3'h0;
      instr_done_q <= 1'b0;
      illegal_op_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      prog_addr_q <= prog_addr_d;
      op_q <= op_d;  arg1_q <= arg1_d;  arg2_q <= arg2_d;
      ea_q <= ea_d;  ea_sfr_q <= ea_sfr_d;  opnd_q <= opnd_d;
      acc_q <= acc_d;  b_q <= b_d;  psw_q <= psw_d;
      pointer_high_byte_q <= dph_d;
      pointer_low_byte_q <= dpl_d;
      port_lat_q <= port_lat_d;
      mc_cnt_q <= mc_cnt_d;
      instr_done_q <= done_d;
      illegal_op_q <= illegal_d;
    end
  end

endmodule : cpu_incdec_div_branch_exec

// ---- design/cpu_exec_pkg.sv ----
package cpu_exec_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // opcodes, full bytes
  localparam logic [7:0] OP_INC_A    = 8'h04;
  localparam logic [7:0] OP_INC_DIR  = 8'h05;
  localparam logic [7:0] OP_DEC_A    = 8'h14;
  localparam logic [7:0] OP_DEC_DIR  = 8'h15;
  localparam logic [7:0] OP_INC_DATA_POINTER = 8'ha3;
  localparam logic [7:0] OP_DIV      = 8'h84;
  localparam logic [7:0] OP_COUNT_DOWN_BRANCH_OP_DIR = 8'hd5;
  localparam logic [7:0] OP_JB       = 8'h20;
  localparam logic [7:0] OP_JBC      = 8'h10;
  localparam logic [7:0] OP_JC       = 8'h40;
  // opcodes matched on upper bits only (register field below)
  localparam logic [6:0] OPH_INC_IND = 7'h03;  // op[7:1]
  localparam logic [6:0] OPH_DEC_IND = 7'h0b;  // op[7:1]
  localparam logic [4:0] OPH_INC_RN  = 5'h01;  // op[7:3]
  localparam logic [4:0] OPH_DEC_RN  = 5'h03;  // op[7:3]
  localparam logic [4:0] OPH_COUNT_DOWN_BRANCH_OP_RN = 5'h1b;  // op[7:3]

  ////////////////////////////////////////////////////////////////////////////////
  // special function register addresses
  localparam logic [7:0] SFR_ACC = 8'he0;
  localparam logic [7:0] SFR_B   = 8'hf0;
  localparam logic [7:0] SFR_PSW = 8'hd0;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_P0  = 8'h80;  // ports at 80/90/a0/b0
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;

  // status word fields
  localparam int PSW_CY  = 7;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV  = 2;

  // reset values
  localparam logic [7:0]  PSW_RST  = 8'h00;
  localparam logic [7:0]  PORT_RST = 8'hff;
  localparam logic [15:0] PC_RST   = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // timing: sys_clk cycles per machine cycle, instruction lengths and counts
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         MC_PERIOD_NS  = 120;
  localparam logic [3:0] MC_CLKS       = 4'(MC_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_DIV = 3'h4;
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam int RAM_AW = 8;
  localparam int RAM_DW = 8;

  typedef enum logic [3:0] {
    CL_NONE = 4'h0, CL_INC = 4'h1, CL_DEC = 4'h2, CL_DATA_POINTER = 4'h3, CL_DIV = 4'h4,
    CL_COUNT_DOWN_BRANCH_OP = 4'h5, CL_JB = 4'h6, CL_JBC = 4'h7, CL_JC = 4'h8
  } op_class_e;

  typedef enum logic [2:0] {
    MD_NONE = 3'h0, MD_ACC = 3'h1, MD_RN = 3'h2, MD_DIR = 3'h3, MD_IND = 3'h4, MD_BIT = 3'h5
  } op_mode_e;

  typedef enum logic [3:0] {
    ST_FETCH = 4'h0, ST_OPC = 4'h1, ST_ARG1 = 4'h2, ST_ARG2 = 4'h3, ST_PREP = 4'h4,
    ST_IND = 4'h5, ST_READ = 4'h6, ST_EXEC = 4'h7, ST_WAIT = 4'h8
  } exec_state_e;

endpackage : cpu_exec_pkg

// ---- design/data_ram.sv ----
`timescale 1ns/10ps
// internal data memory, registered read, one write port
module data_ram (
  // clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             nrst,
  // read port
  input  wire logic [cpu_exec_pkg::RAM_AW-1:0]  raddr,
  output logic      [cpu_exec_pkg::RAM_DW-1:0]  rdata_q,
  // write port
  input  wire logic                             we,
  input  wire logic [cpu_exec_pkg::RAM_AW-1:0]  waddr,
  input  wire logic [cpu_exec_pkg::RAM_DW-1:0]  wdata
);

  logic [cpu_exec_pkg::RAM_DW-1:0] mem [2**cpu_exec_pkg::RAM_AW];

  // array holds no reset so it maps onto plain ram cells
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data come one cycle after the address
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[raddr];
    end
  end

endmodule : data_ram

// ---- verification/cpu_incdec_div_branch_exec_sva.sv ----
`timescale 1ns/10ps
module cpu_incdec_div_branch_exec_sva (
  // clock and reset
  input wire logic            sys_clk,
  input wire logic            nrst,
  // observed state
  input wire logic [3:0][7:0] port_lat_q,
  input wire logic [7:0]      acc_q,
  input wire logic [7:0]      b_q,
  input wire logic [7:0]      psw_q,
  input wire logic [7:0]      pointer_high_byte_q,
  input wire logic [7:0]      pointer_low_byte_q,
  input wire logic            instr_done_q
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  // acc moves by one step or one changed bit unless b moves with it (divide)
  property p_acc_step;
    $changed(acc_q) && $stable(b_q) |-> acc_q == $past(acc_q) + 8'h01
      || acc_q == $past(acc_q) - 8'h01 || $onehot(acc_q ^ $past(acc_q));
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("acc step wrong");

  // b alone moves by one, or a divide leaves a zero remainder
  property p_b_step;
    $changed(b_q) && $stable(acc_q) |-> b_q == $past(b_q) + 8'h01
      || b_q == $past(b_q) - 8'h01 || b_q == 8'h00;
  endproperty
  a_b_step: assert property (p_b_step) else $error("b step wrong");

  // a pin value leaking in would break the one-step relation to the latch
  property p_lat0_step;
    $changed(port_lat_q[0]) |-> port_lat_q[0] == $past(port_lat_q[0]) + 8'h01
      || port_lat_q[0] == $past(port_lat_q[0]) - 8'h01;
  endproperty
  a_lat0_step: assert property (p_lat0_step) else $error("port0 latch step wrong");

  // port1 sees count-down and bit clear only
  property p_lat1_step;
    $changed(port_lat_q[1]) |-> port_lat_q[1] == $past(port_lat_q[1]) - 8'h01
      || ($onehot(port_lat_q[1] ^ $past(port_lat_q[1]))
          && port_lat_q[1] < $past(port_lat_q[1]));
  endproperty
  a_lat1_step: assert property (p_lat1_step) else $error("port1 latch change wrong");

  property p_dpl_step;
    $changed(pointer_low_byte_q) |-> pointer_low_byte_q == $past(pointer_low_byte_q) + 8'h01
      || pointer_low_byte_q == $past(pointer_low_byte_q) - 8'h01;
  endproperty
  a_dpl_step: assert property (p_dpl_step) else $error("pointer low step wrong");

  // low rollover carries exactly one into the high byte
  property p_dph_carry;
    $past(pointer_low_byte_q) == 8'hff && pointer_low_byte_q == 8'h00
      && $changed(pointer_high_byte_q)
      |-> pointer_high_byte_q == $past(pointer_high_byte_q) + 8'h01;
  endproperty
  a_dph_carry: assert property (p_dph_carry) else $error("pointer carry wrong");

  // carry can only rise by a direct status write, never as a side effect
  property p_carry_rise;
    $rose(psw_q[7]) |-> psw_q == $past(psw_q) - 8'h01 || psw_q == $past(psw_q) + 8'h01;
  endproperty
  a_carry_rise: assert property (p_carry_rise) else $error("carry set unexpectedly");

  // one-cycle pulse, then at least eight cycles low before the next pulse
  property p_done_gap;
    $rose(instr_done_q) |=> !instr_done_q [*8];
  endproperty
  a_done_gap: assert property (p_done_gap) else $error("done pulses too close");
endmodule : cpu_incdec_div_branch_exec_sva

bind cpu_incdec_div_branch_exec cpu_incdec_div_branch_exec_sva i_sva (
  .sys_clk(sys_clk), .nrst(nrst), .port_lat_q(port_lat_q), .acc_q(acc_q), .b_q(b_q),
  .psw_q(psw_q), .pointer_high_byte_q(pointer_high_byte_q),
  .pointer_low_byte_q(pointer_low_byte_q), .instr_done_q(instr_done_q)
);

// ---- verification/cpu_incdec_div_branch_exec_test.sv ----
`timescale 1ns/10ps
module cpu_incdec_div_branch_exec_test;
  logic            sys_clk;
  logic            nrst;
  logic [15:0]     prog_addr_q;
  logic [7:0]      prog_data;
  logic [3:0][7:0] port_pins;
  logic [3:0][7:0] port_lat_q;
  logic [7:0]      acc_q;
  logic [7:0]      b_q;
  logic [7:0]      psw_q;
  logic [7:0]      pointer_high_byte_q;
  logic [7:0]      pointer_low_byte_q;
  logic            instr_done_q;
  logic            illegal_op_q;
  int              illegal_seen;
  logic [7:0]      rom [256];
  logic [7:0]      code_q [$];
  int              failures;
  int              samples_checked;
  int              pc;
  int              park;
  int              sel;

  cpu_incdec_div_branch_exec i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .prog_addr_q(prog_addr_q), .prog_data(prog_data),
    .port_pins(port_pins), .port_lat_q(port_lat_q), .acc_q(acc_q), .b_q(b_q),
    .psw_q(psw_q), .pointer_high_byte_q(pointer_high_byte_q),
    .pointer_low_byte_q(pointer_low_byte_q), .instr_done_q(instr_done_q),
    .illegal_op_q(illegal_op_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock and program memory, data settled half a cycle after the address
  always #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) prog_data <= rom[prog_addr_q[7:0]];

  // count illegal pulses at the falling edge, where the one-cycle pulse has settled
  always @(negedge sys_clk) if (illegal_op_q === 1'b1) illegal_seen++;

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_flags(input logic cy, input logic ov);
    chk("carry", {7'h00, cy}, {7'h00, psw_q[7]});
    chk("range", {7'h00, ov}, {7'h00, psw_q[2]});
  endtask : chk_flags

  task automatic final_report;
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // core spins on a bit branch of a port3 pin; dropping that pin lets it run
  // the new code into the next spin, which tests the other pin bit; the park
  // opcode is only fetched once the last instruction of the code is done
  task automatic run_code;
    int k;
    foreach (code_q[i]) rom[pc + 3 + i] = code_q[i];
    park = pc + 3 + code_q.size();
    rom[park] = 8'h20;
    rom[park + 1] = 8'hb0 | 8'(sel ^ 1);
    rom[park + 2] = 8'hfd;
    @(negedge sys_clk);
    port_pins[3][sel] = 1'b0;
    k = 0;
    while (prog_addr_q !== 16'(park + 1) && k < 3000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 3000) begin
      failures++;
      $display("[ERR] code_end expected %h seen %h", 16'(park + 1), prog_addr_q);
      final_report();
    end else begin
      repeat (2) @(negedge sys_clk);
      port_pins[3][sel] = 1'b1;
      sel = sel ^ 1;
      pc = park;
    end
  endtask : run_code

  ////////////////////////////////////////////////////////////////////////////////
  // wrap both ways on acc, direct plus one on b
  task automatic s_wrap;
    code_q = '{8'h14, 8'h04, 8'h14, 8'h05, 8'hf0, 8'h05, 8'hf0};
    run_code();
    chk("acc", 8'hff, acc_q);
    chk("b", 8'h02, b_q);
    chk_flags(1'b0, 1'b0);
  endtask : s_wrap

  // status minus one sets carry, carry branch skips, divide clears flags
  task automatic s_carry_div;
    code_q = '{8'h15, 8'hd0, 8'h40, 8'h01, 8'h04, 8'h84};
    run_code();
    chk("acc", 8'h7f, acc_q);
    chk("b", 8'h01, b_q);
    chk_flags(1'b0, 1'b0);
  endtask : s_carry_div

  // divisor zero: values kept by design choice
  task automatic s_div_zero;
    code_q = '{8'h15, 8'hf0, 8'h84};
    run_code();
    chk("acc", 8'h7f, acc_q);
    chk("b", 8'h00, b_q);
    chk_flags(1'b0, 1'b1);
  endtask : s_div_zero

  // pins differ from latches, so a pin read gives another result
  task automatic s_port_latch;
    code_q = '{8'h05, 8'h80, 8'hd5, 8'h90, 8'h01, 8'h04};
    run_code();
    chk("lat0", 8'h00, port_lat_q[0]);
    chk("lat1", 8'hfe, port_lat_q[1]);
    chk("acc", 8'h7f, acc_q);
  endtask : s_port_latch

  // self loop with a negative displacement, runs until b reaches zero
  task automatic s_count_loop;
    code_q = '{8'h05, 8'hf0, 8'h05, 8'hf0, 8'h05, 8'hf0, 8'hd5, 8'hf0, 8'hfd};
    run_code();
    chk("b", 8'h00, b_q);
    chk("acc", 8'h7f, acc_q);
    chk_flags(1'b0, 1'b1);
  endtask : s_count_loop

  // pins opposite to latch bits: a zero latch bit stays, a one is cleared
  task automatic s_clear_bit;
    @(negedge sys_clk);
    port_pins[1] = 8'h01;
    code_q = '{8'h10, 8'h90, 8'h01, 8'h04, 8'h10, 8'h91, 8'h01, 8'h04};
    run_code();
    chk("lat1", 8'hfc, port_lat_q[1]);
    chk("acc", 8'h80, acc_q);
  endtask : s_clear_bit

  task automatic s_bit_branch;
    code_q = '{8'h20, 8'he7, 8'h01, 8'h04, 8'h20, 8'he0, 8'h01, 8'h04};
    run_code();
    chk("acc", 8'h81, acc_q);
  endtask : s_bit_branch

  // carry clear falls through; an undecoded byte must only raise the illegal pulse
  task automatic s_carry_clear;
    code_q = '{8'h40, 8'h01, 8'h04, 8'h00};
    run_code();
    chk("acc", 8'h82, acc_q);
    chk("illegal", 8'h01, 8'(illegal_seen));
    chk_flags(1'b0, 1'b1);
  endtask : s_carry_clear

  task automatic s_pointer;
    code_q = '{8'h15, 8'h82, 8'ha3};
    run_code();
    chk("dph", 8'h01, pointer_high_byte_q);
    chk("dpl", 8'h00, pointer_low_byte_q);
  endtask : s_pointer

  ////////////////////////////////////////////////////////////////////////////////
  // reset, then each scenario in turn from the first spin at address zero
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    port_pins = 32'hff00_005a;
    failures = 0;
    samples_checked = 0;
    pc = 0;
    sel = 0;
    foreach (rom[i]) rom[i] = 8'h00;
    rom[0] = 8'h20;
    rom[1] = 8'hb0;
    rom[2] = 8'hfd;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (40) @(negedge sys_clk);
    s_wrap();
    s_carry_div();
    s_div_zero();
    s_port_latch();
    s_count_loop();
    s_clear_bit();
    s_bit_branch();
    s_carry_clear();
    s_pointer();
    final_report();
  end
endmodule : cpu_incdec_div_branch_exec_test
